// [verilog/tec_timer.sv]
`timescale 1ns/1ns
`include "tec_map.svh"
// 8-bit timer / event counter with wishbone register access
module tec_timer
	import tec_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        timerPin,
	input  wire logic        powerDown,
	output logic             overflow,
	output logic             timerIrq,
	output logic             wakeUp
);
	tec_control_s control;
	tec_control_s next_control;
	logic [7:0]   preload;
	logic [7:0]   next_preload;
	logic [7:0]   count;
	logic [7:0]   next_count;
	logic         intEnable;
	logic         next_intEnable;
	logic         pendFlag;
	logic         next_pendFlag;
	tec_pw_e      pwState;
	tec_pw_e      next_pwState;
	logic         pinLast;
	logic         ack;
	logic         next_ack;
	logic [31:0]  rdData;
	logic [31:0]  next_rdData;
	logic         ovf;
	logic         next_ovf;
	logic         psTick;
	logic         psActive;
	logic         access;
	logic         wrLane;
	logic         mapped;
	logic         inhibit;
	logic         pinRise;
	logic         pinFall;
	logic         edgeActive;
	logic         edgeReturn;
	logic         step;

	//==========================================================
	// bus decode
	always_comb
	begin
		access = wb_cyc_i && wb_stb_i && !ack;
		wrLane = wb_we_i && wb_sel_i[0];
		mapped = (wb_adr_i == `TEC_ADDR_COUNT) || (wb_adr_i == `TEC_ADDR_CONTROL)
			|| (wb_adr_i == `TEC_ADDR_INTEN) || (wb_adr_i == `TEC_ADDR_STATUS);
		// short inhibit keeps a read value stable; a few lost counts are tolerated
		inhibit = access && (wb_adr_i == `TEC_ADDR_COUNT);
	end

	//==========================================================
	// pin edges; pin is synchronous, one stage of history is enough
	always_comb
	begin
		pinRise = timerPin && !pinLast;
		pinFall = !timerPin && pinLast;
		edgeActive = control.edgeSelect ? pinRise : pinFall;
		edgeReturn = control.edgeSelect ? pinFall : pinRise;
	end

	assign psActive = control.runEnable
		&& (control.modeSelect == TEC_MODE_TIMER
		|| (control.modeSelect == TEC_MODE_PULSE && pwState == TEC_PW_COUNT));

	tec_prescaler u_prescaler
	(
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.active         (psActive),
		.prescaleSelect (control.prescaleSelect),
		.tick           (psTick)
	);

	//==========================================================
	// count step selection per mode
	always_comb
	begin
		step = 1'b0;
		unique case (control.modeSelect)
			TEC_MODE_OFF:   step = 1'b0;
			TEC_MODE_TIMER: step = control.runEnable && psTick;
			// event edges bypass the prescaler and keep going in power-down
			TEC_MODE_EVENT: step = control.runEnable
				&& (control.edgeSelect ? pinFall : pinRise);
			TEC_MODE_PULSE: step = control.runEnable && psTick;
		endcase
		if (inhibit)
			step = 1'b0;
	end

	//==========================================================
	// pulse measurement sequencer
	always_comb
	begin
		next_pwState = pwState;
		if (control.modeSelect != TEC_MODE_PULSE || !control.runEnable)
			next_pwState = TEC_PW_IDLE;
		else
			unique case (pwState)
				TEC_PW_IDLE:  next_pwState = TEC_PW_ARMED;
				TEC_PW_ARMED: if (edgeActive) next_pwState = TEC_PW_COUNT;
				TEC_PW_COUNT: if (edgeReturn) next_pwState = TEC_PW_IDLE;
				default:      next_pwState = TEC_PW_IDLE;
			endcase
	end

	//==========================================================
	// counter and preload: step, wrap and software load
	always_comb
	begin
		next_count = count;
		next_preload = preload;
		next_ovf = 1'b0;
		if (step)
		begin
			if (count == `TEC_COUNT_FULL)
			begin
				next_count = preload;
				next_ovf = 1'b1;
			end
			else
				next_count = count + 8'h01;
		end
		// a load shares its edge with the take; the step is inhibited then, so no clash
		if (access && wrLane && (wb_adr_i == `TEC_ADDR_COUNT))
		begin
			next_preload = wb_dat_i[7:0];
			if (!control.runEnable)
				next_count = wb_dat_i[7:0];
		end
	end

	//==========================================================
	// control, interrupt enable and pending flag
	always_comb
	begin
		next_control = control;
		next_intEnable = intEnable;
		next_pendFlag = pendFlag;
		// hardware clears run only at the end of a measured pulse
		if (control.modeSelect == TEC_MODE_PULSE && pwState == TEC_PW_COUNT && edgeReturn)
			next_control.runEnable = 1'b0;
		if (access && wrLane)
		begin
			unique case (wb_adr_i)
				// mode and run may land in one write; ordering them is left to software
				`TEC_ADDR_CONTROL: next_control = tec_control_s'(wb_dat_i[7:0]);
				`TEC_ADDR_INTEN:   next_intEnable = wb_dat_i[0];
				`TEC_ADDR_STATUS:  if (wb_dat_i[0]) next_pendFlag = 1'b0;
				default:           next_intEnable = intEnable;
			endcase
		end
		// a clear in the overflow cycle loses, so no request is dropped
		if (next_ovf)
			next_pendFlag = 1'b1;
	end

	//==========================================================
	// bus answer: one-cycle ack, error on unmapped word
	always_comb
	begin
		next_ack = access;
		next_rdData = 32'h0000_0000;
		unique case (wb_adr_i)
			`TEC_ADDR_COUNT:   next_rdData = {24'h00_0000, count};
			`TEC_ADDR_CONTROL: next_rdData = {24'h00_0000, control};
			`TEC_ADDR_INTEN:   next_rdData = {31'h0000_0000, intEnable};
			`TEC_ADDR_STATUS:  next_rdData = {30'h0000_0000, control.runEnable, pendFlag};
			default:           next_rdData = 32'h0000_0000;
		endcase
	end

	//==========================================================
	// bus answer registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ack    <= 1'b0;
			rdData <= 32'h0000_0000;
		end
		else
		begin
			ack    <= next_ack;
			rdData <= next_rdData;
		end
	end

	//==========================================================
	// counter, preload and overflow pulse registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			count   <= 8'h00;
			preload <= `TEC_PRELOAD_RESET;
			ovf     <= 1'b0;
		end
		else
		begin
			count   <= next_count;
			preload <= next_preload;
			ovf     <= next_ovf;
		end
	end

	//==========================================================
	// control, interrupt enable and pending flag registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			control   <= tec_control_s'(`TEC_CONTROL_RESET);
			intEnable <= 1'b0;
			pendFlag  <= 1'b0;
		end
		else
		begin
			control   <= next_control;
			intEnable <= next_intEnable;
			pendFlag  <= next_pendFlag;
		end
	end

	//==========================================================
	// pulse sequencer state and pin history
	// pin history resets low; a pin idling high would show one false rise after reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pwState <= TEC_PW_IDLE;
			pinLast <= 1'b0;
		end
		else
		begin
			pwState <= next_pwState;
			pinLast <= timerPin;
		end
	end

	//==========================================================
	// outputs
	assign wb_ack_o = ack && mapped;
	assign wb_err_o = ack && !mapped;
	assign wb_dat_o = rdData;
	assign overflow = ovf;
	assign timerIrq = pendFlag && intEnable;
	assign wakeUp   = ovf && powerDown;
endmodule // tec_timer

// [verilog/tec_map.svh]
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH
// Notes on behaviour
// - timer and pulse modes count prescaled clock; event mode counts pin edges
// - control bits 0..2 pick prescale ratio; ignored when pin is clock
// - counter steps up by one per clock pulse or qualifying pin edge
// - on wrap past FFH: overflow pulse, request, reload from preload, keep counting
// - preload write while stopped also loads the counter at once
// - preload write while running waits for next overflow to reach counter
// - control bits 7:6 select operating mode
// - control bit 4 runs the counter when one, stops it when zero
// - mode 01 is event counting, pin edges bypass the prescaler
// - event mode: edge select 0 counts rising, 1 counts falling edges
// - event mode counts during power-down; overflow raises request and wake-up
// - mode 11 is pulse width measurement on the prescaled clock
// - pulse mode: enable only arms; counting starts on an active pin edge
// - pulse mode: edge 0 counts low pulse, edge 1 counts high pulse
// - pulse mode: enable auto-clears when pin returns, count stays readable
// - timer and event modes never clear the enable bit by hardware
// - after pulse end, pin edges ignored until software sets enable again
// - pulse mode acts on pin transitions; overflow reloads and continues
// - overflow request forwarded only while interrupt enable bit is one
// - counter clock inhibited during count read or preload write access
// - software sets mode bits before enable, not in the same write
//==========================================================
// register map (byte offsets on the bus)
`define TEC_ADDR_COUNT     4'h0
`define TEC_ADDR_CONTROL   4'h4
`define TEC_ADDR_INTEN     4'h8
`define TEC_ADDR_STATUS    4'hC
//==========================================================
// control field positions
`define TEC_PSC_LSB        0
`define TEC_PSC_MSB        2
`define TEC_EDGE_BIT       3
`define TEC_RUN_BIT        4
`define TEC_MODE_LSB       6
`define TEC_MODE_MSB       7
`define TEC_CONTROL_RESET  8'h00
`define TEC_PRELOAD_RESET  8'h00
`define TEC_COUNT_FULL     8'hFF
`define TEC_PSC_WIDTH      8
`endif

// [verilog/tec_pkg.sv]
package tec_pkg;
	typedef enum logic [1:0]
	{
		TEC_MODE_OFF   = 2'h0,
		TEC_MODE_EVENT = 2'h1,
		TEC_MODE_TIMER = 2'h2,
		TEC_MODE_PULSE = 2'h3
	} tec_mode_e;

	typedef enum logic [2:0]
	{
		TEC_PW_IDLE  = 3'h1,
		TEC_PW_ARMED = 3'h2,
		TEC_PW_COUNT = 3'h4
	} tec_pw_e;

	typedef struct packed
	{
		tec_mode_e  modeSelect;
		logic       spare;
		logic       runEnable;
		logic       edgeSelect;
		logic [2:0] prescaleSelect;
	} tec_control_s;
endpackage

// [verilog/tec_prescaler.sv]
`timescale 1ns/1ns
`include "tec_map.svh"
// divider, cleared while inactive, producing one tick every 2^(sel+1) system clocks
module tec_prescaler
	import tec_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       active,
	input  wire logic [2:0] prescaleSelect,
	output logic            tick
);
	logic [`TEC_PSC_WIDTH-1:0] div;
	logic [`TEC_PSC_WIDTH-1:0] next_div;
	logic [`TEC_PSC_WIDTH-1:0] mask;

	//==========================================================
	// divide chain
	always_comb
	begin
		mask = 8'(({1'b0, 8'h01} << ({1'b0, prescaleSelect} + 4'h1)) - 9'h001);
		next_div = active ? div + 8'h01 : 8'h00;
		tick = active && ((div & mask) == mask);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			div <= 8'h00;
		else
			div <= next_div;
	end
endmodule // tec_prescaler

// [verif/tec_timer_chk.sv]
`timescale 1ns/1ns
// port watcher: bus answers, overflow, request and wake-up
module tec_timer_chk
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        powerDown,
	input wire logic        overflow,
	input wire logic        timerIrq,
	input wire logic        wakeUp
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic req;
	// a new request: no answer standing yet
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	//==========================================================
	// checks
	chk_ack_latency: assert property (req && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acked");
	chk_err_unmapped: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	chk_answer_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("answer too long");
	chk_wake_cause: assert property (wakeUp |-> overflow && powerDown)
		else $error("stray wake");
	chk_wake_given: assert property (overflow && powerDown |-> wakeUp)
		else $error("missing wake");
	chk_ovf_pulse: assert property (overflow |=> !overflow)
		else $error("overflow too long");
	chk_irq_cause: assert property ($rose(timerIrq) |->
		overflow || $past(overflow) || $past(overflow, 2) || wb_ack_o && wb_we_i)
		else $error("request without cause");
	chk_irq_masked: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 &&
		wb_sel_i[0] && !wb_dat_i[0] |-> !timerIrq)
		else $error("masked request seen");
	cov_ovf: cover property (overflow);
	cov_wake: cover property (wakeUp);
	cov_err: cover property (wb_err_o);
endmodule // tec_timer_chk
bind tec_timer tec_timer_chk chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .powerDown, .overflow, .timerIrq, .wakeUp);

// [verif/tec_pin_src.sv]
`timescale 1ns/1ns
// outside source on the timer pin; always driven, so no floating level
module tec_pin_src
(
	input  wire logic ref_clk,
	output logic      timerPin
);
	initial timerPin = 1'b0;
	// n level changes, each held gap cycles, launched just after an edge
	task automatic toggle(input int n, input int gap);
		repeat (n)
		begin
			@(posedge ref_clk);
			timerPin <= ~timerPin;
			repeat (gap - 1) @(posedge ref_clk);
		end
	endtask
endmodule // tec_pin_src

// [verif/tec_timer_tb.sv]
`timescale 1ns/1ns
module tec_timer_tb;
	logic        ref_clk = 1'b0, rst_n = 1'b0, wbCyc = 1'b0, wbWe = 1'b0;
	logic        powerDown = 1'b0, sawWake = 1'b0, rdErr;
	logic [3:0]  wbAdr = 4'h0;
	logic [31:0] wbDat = 32'h0, datO, rdVal;
	logic [7:0]  cnt;
	logic        ack, err, overflow, timerIrq, wakeUp, timerPin;
	int          failCount = 0, nTests = 0, cycles = 0, t0;
	tec_timer dut (.ref_clk, .rst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ack),
		.wb_err_o(err), .timerPin, .powerDown, .overflow, .timerIrq, .wakeUp);
	tec_pin_src src (.ref_clk, .timerPin);
	always #2 ref_clk = ~ref_clk;
	// wake memory and hang guard, far above the planned run
	always @(posedge ref_clk)
	begin
		if (wakeUp === 1'b1)
			sawWake <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failCount++;
			test_done;
		end
	end
	//==========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			failCount++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// classic cycle: hold until answered, take data at that edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= {24'h0, d};
		do @(posedge ref_clk); while (ack !== 1'b1 && err !== 1'b1);
		rdVal = datO;
		rdErr = err;
		wbCyc <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 8'h00);
		check(rdVal, exp);
	endtask
	task automatic waitOvf;
		do @(posedge ref_clk); while (overflow !== 1'b1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//==========================================================
	// timer, event, power-down and pulse sequences
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(4'h4, 32'h0);
		wb(1'b0, 4'h2, 8'h00);
		check({31'h0, rdErr}, 32'h1);
		wb(1'b1, 4'h0, 8'hFE);
		rd(4'h0, 32'hFE);
		wb(1'b1, 4'h8, 8'h01);
		wb(1'b1, 4'h4, 8'h87);
		wb(1'b1, 4'h4, 8'h97);
		waitOvf;
		t0 = cycles;
		rd(4'hC, 32'h3);
		check({31'h0, timerIrq}, 32'h1);
		wb(1'b1, 4'h0, 8'h10);
		rd(4'h0, 32'hFE);
		waitOvf;
		check(32'(cycles - t0), 32'h200);
		rd(4'h0, 32'h10);
		wb(1'b1, 4'h8, 8'h00);
		check({31'h0, timerIrq}, 32'h0);
		wb(1'b1, 4'h4, 8'h47);
		wb(1'b1, 4'h0, 8'h00);
		src.toggle(2, 4);
		rd(4'h0, 32'h0);
		wb(1'b1, 4'h4, 8'h57);
		src.toggle(3, 4);
		rd(4'h0, 32'h2);
		wb(1'b1, 4'h4, 8'h4F);
		wb(1'b1, 4'h0, 8'h00);
		wb(1'b1, 4'h4, 8'h5F);
		src.toggle(5, 4);
		rd(4'h0, 32'h3);
		wb(1'b1, 4'hC, 8'h01);
		rd(4'hC, 32'h2);
		wb(1'b1, 4'h4, 8'h47);
		wb(1'b1, 4'h0, 8'hFF);
		powerDown <= 1'b1;
		wb(1'b1, 4'h4, 8'h57);
		src.toggle(2, 4);
		check({31'h0, sawWake}, 32'h1);
		rd(4'h0, 32'hFF);
		powerDown <= 1'b0;
		wb(1'b1, 4'h4, 8'hC0);
		src.toggle(1, 2);
		wb(1'b1, 4'h0, 8'h00);
		wb(1'b1, 4'h4, 8'hD0);
		rd(4'h0, 32'h0);
		src.toggle(2, 20);
		wb(1'b0, 4'h0, 8'h00);
		cnt = rdVal[7:0];
		check({31'h0, cnt >= 8'h08 && cnt <= 8'h0B}, 32'h1);
		rd(4'hC, 32'h1);
		src.toggle(4, 2);
		rd(4'h0, {24'h0, cnt});
		test_done;
	end
endmodule // tec_timer_tb
